// >>> src/ifw_pkg.sv
// What this block does
// R1 - Second supported word: bit 14 one, bit 15 zero, always.
// R2 - Third supported word: bit 14 one, bit 15 zero, always.
// R3 - Third enabled word: bit 14 one, bit 15 zero, always.
// R4 - First supported word bits 0,1,5,6 copy health, security, cache, look-ahead options.
// R5 - First supported word bits 2,4,7,8,9,10 read zero.
// R6 - First supported word bits 3,12,13,14 read one.
// R7 - Second supported word bits 2,10,12,13 read one.
// R8 - Second supported word bit 3 equals power-management-level option.
// R9 - Second supported word bits 0,1,4-9,11 read zero.
// R10 - Third supported word bits 5,6 copy logging and forced-write options.
// R11 - Third supported word bits 0-4, 7-10, 13 read zero.
// R12 - First enabled word bit 0 is health enable, host-changeable, kept over power cycles.
// R13 - First enabled word bit 1 set once a password enables security.
// R14 - First enabled word bits 5,6 show write-cache and look-ahead enables.
// R15 - First enabled word bits 3,12,13,14 one; bits 2,4,7-10 zero.
// R16 - Second enabled word bits 15 and 10 read one.
// R17 - Second enabled word bit 3 follows power-management-level enable by set-features.
// R18 - Second enabled word bits 2,12,13 read one.
// R19 - Second enabled word bits 0,1,4,5,6,8,9,11 read zero.
// R20 - Third enabled word bits 5,6 copy logging and forced-write options.
// R21 - Third enabled word bits 0-4, 7-10, 13 read zero.
// R22 - Host treats all-zero or all-ones words as carrying no indication.
// R23 - Reserved and obsolete bits of all six words read zero.
// R24 - Words are rebuilt from current state on every read.
package ifw_pkg;

  // ----------------------------------------
  // Word indices in the identification data
  // ----------------------------------------
  localparam logic [7:0] IFW_IDX_SUP1 = 8'h52;
  localparam logic [7:0] IFW_IDX_SUP2 = 8'h53;
  localparam logic [7:0] IFW_IDX_SUP3 = 8'h54;
  localparam logic [7:0] IFW_IDX_EN1  = 8'h55;
  localparam logic [7:0] IFW_IDX_EN2  = 8'h56;
  localparam logic [7:0] IFW_IDX_EN3  = 8'h57;

  // ----------------------------------------
  // Bit positions
  // ----------------------------------------
  localparam int IFW_B_HEALTH = 0;
  localparam int IFW_B_SECUR  = 1;
  localparam int IFW_B_PWRLVL = 3;
  localparam int IFW_B_WCACHE = 5;
  localparam int IFW_B_LOOKA  = 6;
  localparam int IFW_B_LOGGP  = 5;
  localparam int IFW_B_FUAWR  = 6;
  localparam int IFW_B_SIG1   = 14;
  localparam int IFW_B_SIG0   = 15;

  // ----------------------------------------
  // Fixed one bits of each word, all else zero
  // ----------------------------------------
  localparam logic [15:0] IFW_SUP1_ONES = 16'h7008;
  localparam logic [15:0] IFW_SUP2_ONES = 16'h7404;
  localparam logic [15:0] IFW_SUP3_ONES = 16'h4000;
  localparam logic [15:0] IFW_EN1_ONES  = 16'h7008;
  localparam logic [15:0] IFW_EN2_ONES  = 16'hb404;
  localparam logic [15:0] IFW_EN3_ONES  = 16'h4000;
  localparam logic [15:0] IFW_ZERO      = 16'h0000;

  // Enable-change pulses from the command decoder
  typedef struct packed {
    logic health_on;
    logic health_off;
    logic secur_set;
    logic secur_off;
    logic wcache_on;
    logic wcache_off;
    logic looka_on;
    logic looka_off;
    logic pwrlvl_on;
    logic pwrlvl_off;
  } ifw_ctl_s;

  // Live enable state
  typedef struct packed {
    logic health;
    logic secur;
    logic wcache;
    logic looka;
    logic pwrlvl;
  } ifw_state_s;

endpackage : ifw_pkg

// >>> src/ifw_feature_words.sv
`timescale 1ns/100ps
module ifw_feature_words
  import ifw_pkg::*;
#(
  parameter bit CAP_HEALTH = 1'b1,
  parameter bit CAP_SECUR  = 1'b1,
  parameter bit CAP_WCACHE = 1'b1,
  parameter bit CAP_LOOKA  = 1'b1,
  parameter bit CAP_PWRLVL = 1'b1,
  parameter bit CAP_LOGGP  = 1'b0,
  parameter bit CAP_FUAWR  = 1'b0
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire ifw_ctl_s    CTL,
  input  wire logic        NV_HEALTH_IN,
  output logic             NV_HEALTH_OUT,
  output logic             NV_HEALTH_WR,
  input  wire logic        RD_REQ,
  input  wire logic [7:0]  RD_WORD,
  output logic             RD_VALID,
  output logic             RD_HIT,
  output logic [15:0]      RD_DATA,
  output ifw_state_s       STATE
);

  // ----------------------------------------
  // Next value of an enable flag, set wins
  // ----------------------------------------
  function automatic logic next_flag(input logic cur, input logic on,
                                     input logic off, input logic cap);
    logic r;
    r = cur;
    if (off) begin
      r = 1'b0;
    end
    if (on && cap) begin
      r = 1'b1;
    end
    return r;
  endfunction : next_flag

  // ----------------------------------------
  // Enable state
  // ----------------------------------------
  logic health_q;
  logic secur_q;
  logic wcache_q;
  logic looka_q;
  logic pwrlvl_q;
  logic loaded_q;
  logic health_d;

  // Health enable, reloaded from storage after reset release
  assign health_d = next_flag(health_q, CTL.health_on, CTL.health_off, CAP_HEALTH);

  // Load flag marks the one-time restore
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
    end
  end

  // Health enable survives power cycles through storage
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      health_q <= 1'b0;
    end else if (!loaded_q) begin
      health_q <= NV_HEALTH_IN & CAP_HEALTH; // R12
    end else begin
      health_q <= health_d; // R12
    end
  end

  // Write-back to storage on every change after restore
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      NV_HEALTH_WR <= 1'b0;
    end else begin
      NV_HEALTH_WR <= loaded_q && (health_d != health_q); // R12
    end
  end

  assign NV_HEALTH_OUT = health_q;

  // Security enabled by a password-setting command
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      secur_q <= 1'b0;
    end else begin
      secur_q <= next_flag(secur_q, CTL.secur_set, CTL.secur_off, CAP_SECUR); // R13
    end
  end

  // Write cache and look-ahead enables
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wcache_q <= 1'b0;
      looka_q  <= 1'b0;
    end else begin
      wcache_q <= next_flag(wcache_q, CTL.wcache_on, CTL.wcache_off, CAP_WCACHE); // R14
      looka_q  <= next_flag(looka_q, CTL.looka_on, CTL.looka_off, CAP_LOOKA); // R14
    end
  end

  // Power-management-level enable by set-features
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwrlvl_q <= 1'b0;
    end else begin
      pwrlvl_q <= next_flag(pwrlvl_q, CTL.pwrlvl_on, CTL.pwrlvl_off, CAP_PWRLVL); // R17
    end
  end

  assign STATE = '{health: health_q, secur: secur_q, wcache: wcache_q,
                   looka: looka_q, pwrlvl: pwrlvl_q};

  // ----------------------------------------
  // Word assembly from live state
  // ----------------------------------------
  logic [15:0] sup1_w;
  logic [15:0] sup2_w;
  logic [15:0] sup3_w;
  logic [15:0] en1_w;
  logic [15:0] en2_w;
  logic [15:0] en3_w;

  // Supported words: fixed ones plus options, all else zero
  always_comb begin
    sup1_w               = IFW_SUP1_ONES; // R5 R6 R23
    sup1_w[IFW_B_HEALTH] = CAP_HEALTH; // R4
    sup1_w[IFW_B_SECUR]  = CAP_SECUR; // R4
    sup1_w[IFW_B_WCACHE] = CAP_WCACHE; // R4
    sup1_w[IFW_B_LOOKA]  = CAP_LOOKA; // R4
    sup2_w               = IFW_SUP2_ONES; // R1 R7 R9
    sup2_w[IFW_B_PWRLVL] = CAP_PWRLVL; // R8
    sup3_w               = IFW_SUP3_ONES; // R2 R11
    sup3_w[IFW_B_LOGGP]  = CAP_LOGGP; // R10
    sup3_w[IFW_B_FUAWR]  = CAP_FUAWR; // R10
  end

  // Enabled words: fixed ones plus current enables; the third word copies the logging and forced-write options
  always_comb begin
    en1_w               = IFW_EN1_ONES; // R15 R23
    en1_w[IFW_B_HEALTH] = health_q; // R12
    en1_w[IFW_B_SECUR]  = secur_q; // R13
    en1_w[IFW_B_WCACHE] = wcache_q; // R14
    en1_w[IFW_B_LOOKA]  = looka_q; // R14
    en2_w               = IFW_EN2_ONES; // R16 R18 R19
    en2_w[IFW_B_PWRLVL] = pwrlvl_q; // R17
    en3_w               = IFW_EN3_ONES; // R3 R21
    en3_w[IFW_B_LOGGP]  = CAP_LOGGP; // R20
    en3_w[IFW_B_FUAWR]  = CAP_FUAWR; // R20
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [15:0] sel_w;
  logic        sel_hit;

  // Word select; other indices belong elsewhere and read zero
  always_comb begin
    sel_hit = 1'b1;
    case (RD_WORD)
      IFW_IDX_SUP1: sel_w = sup1_w;
      IFW_IDX_SUP2: sel_w = sup2_w;
      IFW_IDX_SUP3: sel_w = sup3_w;
      IFW_IDX_EN1:  sel_w = en1_w;
      IFW_IDX_EN2:  sel_w = en2_w;
      IFW_IDX_EN3:  sel_w = en3_w;
      default: begin
        sel_w   = IFW_ZERO;
        sel_hit = 1'b0;
      end
    endcase
  end

  // Registered answer, one cycle after the request
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_VALID <= 1'b0;
      RD_HIT   <= 1'b0;
      RD_DATA  <= IFW_ZERO;
    end else begin
      RD_VALID <= RD_REQ;
      RD_HIT   <= RD_REQ && sel_hit;
      if (RD_REQ) begin
        RD_DATA <= sel_w; // R24
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [7:0] idx_q;

  // Index of the word being answered
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      idx_q <= 8'h00;
    end else if (RD_REQ) begin
      idx_q <= RD_WORD;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_sup2_signature: assert property ( // R1
    RD_VALID && idx_q == IFW_IDX_SUP2 |-> RD_DATA[IFW_B_SIG1] && !RD_DATA[IFW_B_SIG0])
    else $error("second supported word signature wrong");

  chk_sup3_signature: assert property ( // R2
    RD_VALID && idx_q == IFW_IDX_SUP3 |-> RD_DATA[IFW_B_SIG1] && !RD_DATA[IFW_B_SIG0])
    else $error("third supported word signature wrong");

  chk_en3_signature: assert property ( // R3
    RD_VALID && idx_q == IFW_IDX_EN3 |-> RD_DATA[IFW_B_SIG1] && !RD_DATA[IFW_B_SIG0])
    else $error("third enabled word signature wrong");

  chk_sup1_word: assert property ( // R4
    RD_REQ && RD_WORD == IFW_IDX_SUP1 |=> RD_DATA == (IFW_SUP1_ONES
      | (16'(CAP_HEALTH) << IFW_B_HEALTH) | (16'(CAP_SECUR) << IFW_B_SECUR)
      | (16'(CAP_WCACHE) << IFW_B_WCACHE) | (16'(CAP_LOOKA) << IFW_B_LOOKA)))
    else $error("first supported word wrong");

  chk_sup2_pwrlvl: assert property ( // R8
    RD_REQ && RD_WORD == IFW_IDX_SUP2 |=> RD_DATA[IFW_B_PWRLVL] == CAP_PWRLVL
      && (RD_DATA & 16'h0bf3) == 16'h0000)
    else $error("second supported word level bit wrong");

  chk_health_follow: assert property ( // R12
    loaded_q && CTL.health_on && CAP_HEALTH ##1 RD_REQ && RD_WORD == IFW_IDX_EN1
      |=> RD_DATA[IFW_B_HEALTH])
    else $error("health enable not visible");

  chk_health_restore: assert property ( // R12
    !loaded_q |=> health_q == ($past(NV_HEALTH_IN) & CAP_HEALTH))
    else $error("health enable not restored");

  chk_secur_set: assert property ( // R13
    CTL.secur_set && CAP_SECUR |=> secur_q)
    else $error("security enable not set");

  chk_en1_fixed: assert property ( // R15
    RD_VALID && idx_q == IFW_IDX_EN1 |-> (RD_DATA & 16'hf79c) == IFW_EN1_ONES)
    else $error("first enabled word fixed bits wrong");

  chk_en2_word: assert property ( // R17
    RD_REQ && RD_WORD == IFW_IDX_EN2 |=> RD_DATA == (IFW_EN2_ONES
      | (16'($past(pwrlvl_q)) << IFW_B_PWRLVL)))
    else $error("second enabled word wrong");

  chk_pwrlvl_clear: assert property ( // R17
    CTL.pwrlvl_off && !CTL.pwrlvl_on |=> !pwrlvl_q)
    else $error("level enable not cleared");

  chk_unmapped_zero: assert property ( // R23
    RD_VALID && !RD_HIT |-> RD_DATA == IFW_ZERO)
    else $error("unmapped word not zero");

  // ----------------------------------------
  // Checks: whole words against options and state
  // ----------------------------------------
  chk_sup2_word: assert property ( // R7
    RD_REQ && RD_WORD == IFW_IDX_SUP2 |=> RD_DATA == (IFW_SUP2_ONES
      | (16'(CAP_PWRLVL) << IFW_B_PWRLVL)))
    else $error("second supported word wrong");

  chk_sup3_word: assert property ( // R10
    RD_REQ && RD_WORD == IFW_IDX_SUP3 |=> RD_DATA == (IFW_SUP3_ONES
      | (16'(CAP_LOGGP) << IFW_B_LOGGP) | (16'(CAP_FUAWR) << IFW_B_FUAWR)))
    else $error("third supported word wrong");

  chk_en3_word: assert property ( // R20
    RD_REQ && RD_WORD == IFW_IDX_EN3 |=> RD_DATA == (IFW_EN3_ONES
      | (16'(CAP_LOGGP) << IFW_B_LOGGP) | (16'(CAP_FUAWR) << IFW_B_FUAWR)))
    else $error("third enabled word wrong");

  chk_en1_word: assert property ( // R14
    RD_REQ && RD_WORD == IFW_IDX_EN1 |=> RD_DATA == (IFW_EN1_ONES
      | (16'($past(health_q)) << IFW_B_HEALTH) | (16'($past(secur_q)) << IFW_B_SECUR)
      | (16'($past(wcache_q)) << IFW_B_WCACHE) | (16'($past(looka_q)) << IFW_B_LOOKA)))
    else $error("first enabled word wrong");

  // ----------------------------------------
  // Checks: enable flags
  // ----------------------------------------
  chk_health_clear: assert property ( // R12
    loaded_q && CTL.health_off && !CTL.health_on |=> !health_q)
    else $error("health enable not cleared");

  chk_health_hold: assert property ( // R12
    loaded_q && !CTL.health_on && !CTL.health_off |=> $stable(health_q))
    else $error("health enable changed without a pulse");

  chk_secur_clear: assert property ( // R13
    CTL.secur_off && !CTL.secur_set |=> !secur_q)
    else $error("security enable not cleared");

  chk_secur_hold: assert property ( // R13
    !CTL.secur_set && !CTL.secur_off |=> $stable(secur_q))
    else $error("security enable changed without a pulse");

  chk_wcache_set: assert property ( // R14
    CTL.wcache_on && CAP_WCACHE |=> wcache_q)
    else $error("write cache enable not set");

  chk_wcache_clear: assert property ( // R14
    CTL.wcache_off && !CTL.wcache_on |=> !wcache_q)
    else $error("write cache enable not cleared");

  chk_wcache_hold: assert property ( // R14
    !CTL.wcache_on && !CTL.wcache_off |=> $stable(wcache_q))
    else $error("write cache enable changed without a pulse");

  chk_looka_set: assert property ( // R14
    CTL.looka_on && CAP_LOOKA |=> looka_q)
    else $error("look-ahead enable not set");

  chk_looka_clear: assert property ( // R14
    CTL.looka_off && !CTL.looka_on |=> !looka_q)
    else $error("look-ahead enable not cleared");

  chk_looka_hold: assert property ( // R14
    !CTL.looka_on && !CTL.looka_off |=> $stable(looka_q))
    else $error("look-ahead enable changed without a pulse");

  chk_pwrlvl_set: assert property ( // R17
    CTL.pwrlvl_on && CAP_PWRLVL |=> pwrlvl_q)
    else $error("level enable not set");

  chk_pwrlvl_hold: assert property ( // R17
    !CTL.pwrlvl_on && !CTL.pwrlvl_off |=> $stable(pwrlvl_q))
    else $error("level enable changed without a pulse");

  // ----------------------------------------
  // Checks: read port
  // ----------------------------------------
  chk_valid_follow: assert property ( // R24
    RD_REQ |=> RD_VALID)
    else $error("answer missing after request");

  chk_valid_quiet: assert property ( // R24
    !RD_REQ |=> !RD_VALID && $stable(RD_DATA))
    else $error("answer without request");

  chk_hit_mapped: assert property ( // R23
    RD_REQ && RD_WORD >= IFW_IDX_SUP1 && RD_WORD <= IFW_IDX_EN3 |=> RD_HIT)
    else $error("mapped word not flagged");

  chk_hit_unmapped: assert property ( // R23
    RD_REQ && (RD_WORD < IFW_IDX_SUP1 || RD_WORD > IFW_IDX_EN3) |=> !RD_HIT)
    else $error("unmapped word flagged");

  // ----------------------------------------
  // Checks: health storage
  // ----------------------------------------
  chk_nv_write_on: assert property ( // R12
    loaded_q && CTL.health_on && CAP_HEALTH && !health_q
      |=> NV_HEALTH_WR && NV_HEALTH_OUT)
    else $error("health enable not written to storage");

  chk_nv_write_off: assert property ( // R12
    loaded_q && CTL.health_off && !CTL.health_on && health_q
      |=> NV_HEALTH_WR && !NV_HEALTH_OUT)
    else $error("health disable not written to storage");

  chk_nv_quiet: assert property ( // R12
    !CTL.health_on && !CTL.health_off |=> !NV_HEALTH_WR)
    else $error("storage written without a change");

  cov_health_toggle: cover property (CTL.health_on ##[1:20] CTL.health_off);
  cov_en1_read: cover property (RD_REQ && RD_WORD == IFW_IDX_EN1 && wcache_q);
  cov_secur_on: cover property (!secur_q ##1 secur_q);
  cov_nv_write: cover property (NV_HEALTH_WR);
  cov_unmapped_read: cover property (RD_VALID && !RD_HIT);

endmodule : ifw_feature_words

// >>> testbench/ifw_host_model.sv
`timescale 1ns/100ps
module ifw_host_model (
  input  wire logic        clk,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data,
  input  wire logic        nv_out,
  input  wire logic        nv_wr,
  output logic             nv_in,
  output logic             no_ind
);
  // ----------------------------------------
  // Non-volatile health store
  // ----------------------------------------
  // Survives card resets; only the write strobe changes it
  logic store_q = 1'b1;
  always @(posedge clk) begin
    if (nv_wr === 1'b1) begin
      store_q <= nv_out;
    end
  end

  assign nv_in = store_q;

  // Host view: all-zero or all-ones word carries no indication
  assign no_ind = rd_valid && (rd_data == 16'h0000 || rd_data == 16'hffff);
endmodule : ifw_host_model

// >>> testbench/ifw_feature_words_bench.sv
`timescale 1ns/100ps
module ifw_feature_words_bench
  import ifw_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  ifw_ctl_s    ctl = '0;
  logic        rd_req = 1'b0;
  logic [7:0]  rd_word = 8'h00;
  logic        rd_valid, rd_hit, nv_out, nv_wr, nv_in, no_ind;
  logic [15:0] rd_data;
  ifw_state_s  state;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [16:0] exp_q[$];
  logic [31:0] lfsr = 32'h4c4a5787;
  logic        h = 1'b1, s = 1'b0, w = 1'b0, l = 1'b0, p = 1'b0;

  // ----------------------------------------
  // Clock, design and host model
  // ----------------------------------------
  always #20 clk = ~clk;

  ifw_feature_words DUT (.CLK(clk), .RST_N(rst_n), .CTL(ctl), .NV_HEALTH_IN(nv_in),
    .NV_HEALTH_OUT(nv_out), .NV_HEALTH_WR(nv_wr), .RD_REQ(rd_req), .RD_WORD(rd_word),
    .RD_VALID(rd_valid), .RD_HIT(rd_hit), .RD_DATA(rd_data), .STATE(state));

  ifw_host_model host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .nv_out(nv_out),
    .nv_wr(nv_wr), .nv_in(nv_in), .no_ind(no_ind));

  // Expected {hit, word} from the live enable model
  function automatic logic [16:0] exp_word(input logic [7:0] idx);
    case (idx)
      8'h52:   return {1'b1, 16'h706b};
      8'h53:   return {1'b1, 16'h740c};
      8'h54:   return {1'b1, 16'h4000};
      8'h55:   return {1'b1, 16'h7008 | {9'h0, l, w, 3'h0, s, h}};
      8'h56:   return {1'b1, 16'hb404 | {12'h0, p, 3'h0}};
      8'h57:   return {1'b1, 16'h4000};
      default: return 17'h00000;
    endcase
  endfunction : exp_word

  // Next value of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // One cycle of stimulus; a read sees pulses of earlier cycles only
  task automatic step(input ifw_ctl_s c, input logic rq, input logic [7:0] idx);
    @(posedge clk);
    #1;
    ctl = c;
    rd_req = rq;
    rd_word = idx;
    if (rq) exp_q.push_back(exp_word(idx));
    h = c.health_on | (h & ~c.health_off);
    s = c.secur_set | (s & ~c.secur_off);
    w = c.wcache_on | (w & ~c.wcache_off);
    l = c.looka_on | (l & ~c.looka_off);
    p = c.pwrlvl_on | (p & ~c.pwrlvl_off);
  endtask : step

  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // Monitor: oldest expectation against each answer
  // ----------------------------------------
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check(17'h1ffff, 17'h0, "unexpected answer");
      else check({rd_hit, rd_data}, exp_q.pop_front(), "read word");
      if (rd_hit === 1'b1) check({16'h0, no_ind}, 17'h0, "empty-looking word");
    end
  end

  // Watchdog
  initial begin
    #(3000 * 40);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 6; i++) step('0, 1'b1, 8'h52 + 8'(i));
    step('0, 1'b1, 8'h51);
    step('0, 1'b1, 8'h58);
    // Walk every pulse, reading straight after
    for (int i = 0; i < 10; i++) begin
      step(ifw_ctl_s'(10'h200 >> i), 1'b1, 8'h55);
      step('0, 1'b1, 8'h55);
      step('0, 1'b1, 8'h56);
    end
    step('1, 1'b0, 8'h00);
    step('0, 1'b1, 8'h55);
    // Random pulses and reads, mapped and unmapped
    for (int i = 0; i < 500; i++) begin
      lfsr = lfsr_next(lfsr);
      step(ifw_ctl_s'(lfsr[9:0] & lfsr[19:10]), lfsr[20], 8'h50 + 8'(lfsr[23:21]));
    end
    repeat (3) step('0, 1'b0, 8'h00);
    check({12'h0, state}, {12'h0, h, s, w, l, p}, "enable flags");
    // Second reset: health kept, other enables cleared
    @(posedge clk);
    #1 rst_n = 1'b0;
    {s, w, l, p} = 4'h0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    step('0, 1'b1, 8'h55);
    step('0, 1'b1, 8'h56);
    repeat (3) step('0, 1'b0, 8'h00);
    check({16'h0, nv_out}, {16'h0, h}, "health after reset");
    if (exp_q.size() != 0) check(17'(exp_q.size()), 17'h0, "missing answers");
    end_sim();
  end
endmodule : ifw_feature_words_bench
